// ### src/mtcc_pkg.sv
// Constants and types shared by the timer match/capture block
// Operation
// - Compare-match fires in the last clock state of counter/compare equality.
// - After equality, match is held off until just before next count edge.
// - Each compare-match drives the pin to the level the pin control selects.
// - Clear on match happens in final matching state; period is N+1.
// - Counter clear in write state two wins; written value is dropped.
// - Count-up in write state two loses; written value is stored.
// - Buffer transfer during write: channel 0 moves new data, channels 3/4 old.
// - Capture in read state one makes the read return the captured value.
// - Software clears a flag only by reading it as 1 then writing 0.
// - Transfer engine activation clears its match/capture flag automatically.
// - Up count wrap from maximum to zero sets overflow flag and request.
// - Down count from zero to maximum sets underflow flag and request.
// - Channel 4 complementary mode sets overflow reaching zero counting down.
// - Compare-match sets the match/capture flag, then its interrupt request.
// - Input capture sets the match/capture flag, then its interrupt request.
// - Interrupt request stands only while flag and enable are both 1; the code registers it, so it rises and falls one clock after them.
// - Only channels 1 and 2 have underflow; each channel has one overflow.
// - Trigger enable plus register A flag set issues a conversion start.
package mtcc_pkg;
   localparam int          CNT_W     = 16;
   localparam int          NREG      = 4;
   localparam int          NFLAG     = 6;
   localparam logic [15:0] CNT_MAX   = 16'hffff;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;
   localparam logic [15:0] CNT_ONE   = 16'h0001;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] GCC_RST   = 16'hffff;
   // Register select codes of the processor access
   localparam logic [2:0]  SEL_COUNT = 3'h0;
   localparam logic [2:0]  SEL_GCC_A = 3'h1;
   localparam logic [2:0]  SEL_FLAGS = 3'h5;
   // Flag bit positions
   localparam int          FLG_OVF   = 4;
   localparam int          FLG_UNF   = 5;
   localparam int          REG_A     = 0;
   localparam int          REG_C     = 2;
   // Pin level selections
   localparam logic [1:0]  PIN_HOLD  = 2'h0;
   localparam logic [1:0]  PIN_LOW   = 2'h1;
   localparam logic [1:0]  PIN_HIGH  = 2'h2;
   localparam logic [1:0]  PIN_TOG   = 2'h3;
   // Capture edge selections
   localparam logic [1:0]  EDGE_RISE = 2'h1;
   localparam logic [1:0]  EDGE_FALL = 2'h2;
   // Processor bus cycle states
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_T1   = 3'b010,
      BUS_T2   = 3'b100
   } mtcc_bus_t;
endpackage

// ### src/mtcc_capture_edge.sv
// Input capture edge detector for one compare/capture pin
`timescale 1ns/1ps
module mtcc_capture_edge (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Pin and edge choice
   input  wire logic       pin_in,
   input  wire logic [1:0] edge_sel,
   // Detected edge
   output logic            edge_pulse
);
   import mtcc_pkg::*;
   logic prev_reg;

   // Previous pin level
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= pin_in;
      end
   end

   // Rising, falling or both edges
   always_comb begin
      edge_pulse = ((edge_sel[0] && pin_in && !prev_reg) ||
                    (edge_sel[1] && !pin_in && prev_reg));
   end
endmodule

// ### src/mtcc_timer.sv
// One timer channel: counter, four compare/capture registers, flags and bus cycle
`timescale 1ns/1ps
module mtcc_timer #(
   parameter int unsigned CH_ID = 0
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   // Counting control
   input  wire logic                  count_tick,
   input  wire logic                  count_down,
   input  wire logic                  clear_on_match_a,
   input  wire logic                  clear_on_capture_a,
   input  wire logic                  cpwm_mode,
   input  wire logic                  buffer_en,
   // Per register setup
   input  wire logic [3:0]            capture_mode,
   input  wire logic [7:0]            pin_io_control,
   input  wire logic [7:0]            capture_edge_sel,
   // Compare/capture pins
   input  wire logic [3:0]            compare_capture_pin_in,
   output logic      [3:0]            compare_capture_pin_out,
   output logic      [3:0]            compare_capture_pin_oe,
   // Processor access
   input  wire logic                  cpu_start,
   input  wire logic                  cpu_write,
   input  wire logic [2:0]            cpu_sel,
   input  wire logic [15:0]           cpu_wdata,
   output logic      [15:0]           cpu_rdata,
   output logic                       cpu_done,
   // Interrupt and trigger side
   input  wire logic [5:0]            irq_enable_bits,
   input  wire logic                  conversion_trigger_enable,
   input  wire logic [3:0]            transfer_ack,
   output logic      [3:0]            match_capture_irq,
   output logic                       overflow_irq,
   output logic                       underflow_irq,
   output logic                       conversion_start,
   output logic      [5:0]            timer_flags,
   output logic      [3:0]            compare_match
);
   import mtcc_pkg::*;

   localparam bit HAS_UNF = (CH_ID == 1) || (CH_ID == 2);

   mtcc_bus_t    bus_reg;
   logic         bus_wr_reg;
   logic [2:0]   bus_sel_reg;
   logic [15:0]  bus_data_reg;
   logic [15:0]  timer_count_reg;
   logic [15:0]  gcc_reg [NREG];
   logic [15:0]  gcc_next [NREG];
   logic [3:0]   pin_reg;
   logic [3:0]   pin_next;
   logic [3:0]   oe_reg;
   logic [5:0]   flags_reg;
   logic [5:0]   flags_next;
   logic [5:0]   armed_reg;
   logic [5:0]   irq_reg;
   logic [15:0]  rdata_reg;
   logic         done_reg;
   logic         conv_reg;
   logic [3:0]   match_reg;
   logic [3:0]   cap_edge;
   logic [3:0]   cap;
   logic [3:0]   match;
   logic         in_t2;
   logic         wr_t2;
   logic         wr_cnt;
   logic         clr_req;
   logic         ovf_ev;
   logic         unf_ev;
   logic [5:0]   flag_set;
   logic [5:0]   flag_clr;

   // Two-state bus cycle decode
   assign in_t2  = (bus_reg == BUS_T2);
   assign wr_t2  = in_t2 && bus_wr_reg;
   assign wr_cnt = wr_t2 && (bus_sel_reg == SEL_COUNT);

   // Clear on match/capture and overflow/underflow events
   assign clr_req = (clear_on_match_a && match[REG_A]) ||
                    (clear_on_capture_a && cap[REG_A]);
   assign ovf_ev  = count_tick && !wr_cnt && !clr_req &&
                    ((!count_down && timer_count_reg == CNT_MAX) ||
                     (CH_ID == 4 && cpwm_mode && count_down &&
                      timer_count_reg == CNT_ONE));
   assign unf_ev  = HAS_UNF && count_tick && !wr_cnt && !clr_req && count_down &&
                    (timer_count_reg == CNT_ZERO);

   // Per register match, capture, buffer and pin logic
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         mtcc_capture_edge u_edge (
            .ref_clk    (ref_clk),
            .resetn     (resetn),
            .pin_in     (compare_capture_pin_in[gi]),
            .edge_sel   (capture_edge_sel[2*gi+1:2*gi]),
            .edge_pulse (cap_edge[gi])
         );
         assign cap[gi]   = cap_edge[gi] && capture_mode[gi];
         assign match[gi] = !capture_mode[gi] && count_tick &&
                            (timer_count_reg == gcc_reg[gi]);
         if (gi == REG_A) begin : g_a
            // Buffer transfer C to A on match, with write contention
            assign gcc_next[gi] =
               cap[gi] ? timer_count_reg :
               (buffer_en && match[gi]) ?
                  ((CH_ID == 0 && wr_t2 && bus_sel_reg == SEL_GCC_A + 3'(REG_C)) ?
                    bus_data_reg : gcc_reg[REG_C]) :
               (wr_t2 && bus_sel_reg == SEL_GCC_A + 3'(gi)) ? bus_data_reg :
               gcc_reg[gi];
         end else if (gi == REG_C) begin : g_c
            // Capture into A pushes old A into the buffer
            assign gcc_next[gi] =
               cap[gi] ? timer_count_reg :
               (buffer_en && cap[REG_A]) ? gcc_reg[REG_A] :
               (wr_t2 && bus_sel_reg == SEL_GCC_A + 3'(gi)) ? bus_data_reg :
               gcc_reg[gi];
         end else begin : g_bd
            assign gcc_next[gi] =
               cap[gi] ? timer_count_reg :
               (wr_t2 && bus_sel_reg == SEL_GCC_A + 3'(gi)) ? bus_data_reg :
               gcc_reg[gi];
         end
         // Pin level chosen by pin control on each match
         assign pin_next[gi] =
            !match[gi] ? pin_reg[gi] :
            (pin_io_control[2*gi+1:2*gi] == PIN_LOW)  ? 1'b0 :
            (pin_io_control[2*gi+1:2*gi] == PIN_HIGH) ? 1'b1 :
            (pin_io_control[2*gi+1:2*gi] == PIN_TOG)  ? !pin_reg[gi] :
            pin_reg[gi];
      end
   endgenerate

   // Flag set and clear terms
   assign flag_set = {unf_ev, ovf_ev, match | cap};
   assign flag_clr = ({6{wr_t2 && bus_sel_reg == SEL_FLAGS}} &
                      ~bus_data_reg[5:0] & armed_reg) |
                     {2'b00, transfer_ack};
   assign flags_next = flag_set | (flags_reg & ~flag_clr);

   // Processor bus cycle sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bus_reg      <= BUS_IDLE;
         bus_wr_reg   <= 1'b0;
         bus_sel_reg  <= 3'h0;
         bus_data_reg <= 16'h0000;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (cpu_start) begin
                  bus_reg      <= BUS_T1;
                  bus_wr_reg   <= cpu_write;
                  bus_sel_reg  <= cpu_sel;
                  bus_data_reg <= cpu_wdata;
               end
            end
            BUS_T1:  bus_reg <= BUS_T2;
            BUS_T2:  bus_reg <= BUS_IDLE;
            default: bus_reg <= BUS_IDLE;
         endcase
      end
   end

   // Counter with clear over write over count
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         timer_count_reg <= CNT_RST;
      end else if (clr_req) begin
         timer_count_reg <= CNT_ZERO;
      end else if (wr_cnt) begin
         timer_count_reg <= bus_data_reg;
      end else if (count_tick) begin
         timer_count_reg <= count_down ? timer_count_reg - CNT_ONE
                                       : timer_count_reg + CNT_ONE;
      end
   end

   // Compare/capture registers and pins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NREG; i++) begin
            gcc_reg[i] <= GCC_RST;
         end
         pin_reg   <= 4'h0;
         oe_reg    <= 4'h0;
         match_reg <= 4'h0;
      end else begin
         for (int i = 0; i < NREG; i++) begin
            gcc_reg[i] <= gcc_next[i];
         end
         pin_reg   <= pin_next;
         oe_reg    <= ~capture_mode;
         match_reg <= match;
      end
   end

   // Flags, read arming, interrupt requests and trigger
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flags_reg <= 6'h00;
         armed_reg <= 6'h00;
         irq_reg   <= 6'h00;
         conv_reg  <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         if (in_t2 && !bus_wr_reg && bus_sel_reg == SEL_FLAGS) begin
            armed_reg <= flags_reg;
         end else begin
            armed_reg <= armed_reg & ~flag_clr;
         end
         irq_reg  <= flags_reg & irq_enable_bits &
                     {HAS_UNF, 5'h1f};
         conv_reg <= conversion_trigger_enable && flag_set[REG_A];
      end
   end

   // Read data taken in state two, after any state one capture
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 16'h0000;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= in_t2;
         if (in_t2 && !bus_wr_reg) begin
            case (bus_sel_reg)
               3'h0:    rdata_reg <= timer_count_reg;
               3'h1:    rdata_reg <= gcc_reg[0];
               3'h2:    rdata_reg <= gcc_reg[1];
               3'h3:    rdata_reg <= gcc_reg[2];
               3'h4:    rdata_reg <= gcc_reg[3];
               3'h5:    rdata_reg <= {10'h000, flags_reg};
               default: rdata_reg <= 16'h0000;
            endcase
         end
      end
   end

   // Outputs straight from flip-flops
   assign compare_capture_pin_out = pin_reg;
   assign compare_capture_pin_oe  = oe_reg;
   assign cpu_rdata               = rdata_reg;
   assign cpu_done                = done_reg;
   assign match_capture_irq       = irq_reg[3:0];
   assign overflow_irq            = irq_reg[FLG_OVF];
   assign underflow_irq           = irq_reg[FLG_UNF];
   assign conversion_start        = conv_reg;
   assign timer_flags             = flags_reg;
   assign compare_match           = match_reg;

   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_clear_beats_write: assert property (clr_req && wr_cnt |=> timer_count_reg == CNT_ZERO)
      else $error("counter write overrode clear");
   a_write_beats_inc: assert property (wr_cnt && !clr_req && count_tick |=>
      timer_count_reg == $past(bus_data_reg))
      else $error("increment overrode counter write");
   a_match_needs_tick: assert property (!count_tick |=> match_reg == 4'h0)
      else $error("match without count edge");
   a_period_wrap: assert property (clear_on_match_a && match[0] |=>
      timer_count_reg == CNT_ZERO ##0 flags_reg[0])
      else $error("clear on match missed");
   a_ovf_flag_set: assert property (count_tick && !count_down && !wr_cnt && !clr_req &&
      timer_count_reg == CNT_MAX |=> flags_reg[FLG_OVF] && timer_count_reg == CNT_ZERO)
      else $error("overflow flag not set");
   a_unf_flag_set: assert property (unf_ev |=> flags_reg[FLG_UNF] &&
      timer_count_reg == CNT_MAX)
      else $error("underflow flag not set");
   a_irq_follows: assert property (##1 irq_reg[FLG_OVF] ==
      $past(flags_reg[FLG_OVF] && irq_enable_bits[FLG_OVF]))
      else $error("overflow request not tied to flag");
   a_clear_needs_arm: assert property (flags_reg[FLG_OVF] && !armed_reg[FLG_OVF] &&
      !ovf_ev |=> flags_reg[FLG_OVF])
      else $error("flag cleared without read");
   a_xfer_clears: assert property (transfer_ack[0] && !flag_set[0] |=> !flags_reg[0])
      else $error("transfer did not clear flag");
   a_conv_req: assert property (conversion_trigger_enable && flag_set[0] |=>
      conversion_start && flags_reg[0])
      else $error("conversion start missing");
   a_cap_read: assert property (bus_reg == BUS_T1 && !bus_wr_reg &&
      bus_sel_reg == SEL_GCC_A && cap[0] |=> ##1 cpu_rdata == $past(timer_count_reg, 2))
      else $error("read missed capture value");
endmodule

// ### bench/mtcc_xfer_model.sv
// Transfer engine stand-in that answers timer requests with one acknowledge
`timescale 1ns/1ps
module mtcc_xfer_model #(
   parameter int DELAY = 2
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Requests, enables and answers
   input  wire logic [3:0] req,
   input  wire logic [3:0] xfer_en,
   output logic      [3:0] ack
);
   int wait_cnt;

   // Waits DELAY cycles on an enabled request, then pulses ack once
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack      <= 4'h0;
         wait_cnt <= 0;
      end else if (ack != 4'h0 || (req & xfer_en) == 4'h0) begin
         ack      <= 4'h0;
         wait_cnt <= 0;
      end else if (wait_cnt == DELAY) begin
         ack      <= req & xfer_en;
         wait_cnt <= 0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// ### bench/tb.sv
// Self-checking bench for timer channel 1, channel 0 and 4 copies and the transfer engine
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb;
   import mtcc_pkg::*;
   logic        ref_clk = 0;
   logic        resetn = 0;
   logic        tick = 0;
   logic        down = 0;
   logic        clr_a = 0;
   logic        no_sig = 0;
   logic [3:0]  cap_mode = 4'h0;
   logic [7:0]  pin_ctl = 8'h00;
   logic [7:0]  edge_sel = 8'h00;
   logic [3:0]  pin_in = 4'h0;
   logic        start = 0;
   logic        wr = 0;
   logic [2:0]  sel = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic [5:0]  irq_en = 6'h3f;
   logic        trig_en = 1;
   logic [3:0]  xfer_en = 4'h0;
   logic        buf_en = 0;
   logic [1:0][15:0] alt_rdata;
   logic [1:0][5:0]  alt_flags;
   logic [3:0]  ack, mc_irq, cmatch, pin_out, pin_oe;
   logic [15:0] rdata, rd;
   logic        done, ovf_irq, unf_irq, conv;
   logic [5:0]  flags;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   logic [1:0]  lvl_tab [4] = '{PIN_HIGH, PIN_LOW, PIN_TOG, PIN_HOLD};

   // Channel under test and the transfer engine model
   mtcc_timer #(.CH_ID(1)) mtcc_timer_inst (
      .ref_clk(ref_clk), .resetn(resetn), .count_tick(tick), .count_down(down),
      .clear_on_match_a(clr_a), .clear_on_capture_a(no_sig), .cpwm_mode(no_sig),
      .buffer_en(no_sig), .capture_mode(cap_mode), .pin_io_control(pin_ctl),
      .capture_edge_sel(edge_sel), .compare_capture_pin_in(pin_in),
      .compare_capture_pin_out(pin_out), .compare_capture_pin_oe(pin_oe),
      .cpu_start(start), .cpu_write(wr), .cpu_sel(sel), .cpu_wdata(wdata),
      .cpu_rdata(rdata), .cpu_done(done), .irq_enable_bits(irq_en),
      .conversion_trigger_enable(trig_en), .transfer_ack(ack),
      .match_capture_irq(mc_irq), .overflow_irq(ovf_irq), .underflow_irq(unf_irq),
      .conversion_start(conv), .timer_flags(flags), .compare_match(cmatch));
   mtcc_xfer_model mtcc_xfer_model_inst (
      .ref_clk(ref_clk), .resetn(resetn), .req(mc_irq), .xfer_en(xfer_en), .ack(ack));

   // Channel 0 and channel 4 copies for buffer contention and down count overflow
   for (genvar gc = 0; gc < 2; gc++) begin : g_alt
      mtcc_timer #(.CH_ID(4 * gc)) mtcc_timer_inst (
         .ref_clk(ref_clk), .resetn(resetn), .count_tick(tick), .count_down(down),
         .clear_on_match_a(clr_a), .clear_on_capture_a(no_sig), .cpwm_mode(1'b1),
         .buffer_en(buf_en), .capture_mode(cap_mode), .pin_io_control(pin_ctl),
         .capture_edge_sel(edge_sel), .compare_capture_pin_in(pin_in),
         .compare_capture_pin_out(), .compare_capture_pin_oe(),
         .cpu_start(start), .cpu_write(wr), .cpu_sel(sel), .cpu_wdata(wdata),
         .cpu_rdata(alt_rdata[gc]), .cpu_done(), .irq_enable_bits(irq_en),
         .conversion_trigger_enable(trig_en), .transfer_ack(4'h0),
         .match_capture_irq(), .overflow_irq(), .underflow_irq(),
         .conversion_start(), .timer_flags(alt_flags[gc]), .compare_match());
   end

   // Clock and hang guard
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Bus cycle: request held until done is seen, then released
   task automatic bus(input logic w, input logic [2:0] s, input logic [15:0] d);
      int n;
      start = 1;
      wr    = w;
      sel   = s;
      wdata = d;
      n     = 0;
      do begin @(negedge ref_clk); n++; end while (done !== 1'b1 && n < 8);
      start = 0;
      rd    = rdata;
      `CHK(n, 3)
   endtask

   // Write with a count edge landing in the second bus state
   task automatic wr_tick(input logic [2:0] s, input logic [15:0] d);
      fork
         bus(1, s, d);
         begin
            repeat (2) @(negedge ref_clk);
            tick = 1;
            @(negedge ref_clk);
            tick = 0;
         end
      join
   endtask

   task automatic wait_bit(input int b, input logic lv);
      int n;
      n = 0;
      while (flags[b] !== lv && n < 12) begin @(negedge ref_clk); n++; end
   endtask

   task automatic t_match();
      int n;
      bus(0, SEL_GCC_A, 16'h0);
      `CHK(rd, GCC_RST)
      bus(1, SEL_GCC_A, 16'h0003);
      clr_a = 1;
      tick  = 1;
      for (int k = 0; k < 4; k++) begin
         pin_ctl = {6'h0, lvl_tab[k]};
         n = 0;
         do begin @(negedge ref_clk); n++; end while (cmatch[0] !== 1'b1 && n < 20);
         `CHK(n, 4)
         `CHK(pin_out[0], 4'b1101 >> k & 1'b1)
         `CHK(flags[0], 1'b1)
         `CHK(conv, 1'b1)
         if (k == 0) `CHK(mc_irq[0], 1'b0)
      end
      tick = 0;
      `CHK(mc_irq[0], 1'b1)
      irq_en = 6'h3e;
      @(negedge ref_clk);
      `CHK(mc_irq[0], 1'b0)
      irq_en = 6'h3f;
      bus(1, SEL_FLAGS, 16'h0);
      `CHK(flags[0], 1'b1)
      bus(0, SEL_FLAGS, 16'h0);
      `CHK(rd[0], 1'b1)
      bus(1, SEL_FLAGS, 16'h0);
      `CHK(flags[0], 1'b0)
      @(negedge ref_clk);
      `CHK(mc_irq[0], 1'b0)
      xfer_en = 4'h1;
      tick    = 1;
      repeat (4) @(negedge ref_clk);
      tick = 0;
      `CHK(flags[0], 1'b1)
      wait_bit(0, 1'b0);
      `CHK(flags[0], 1'b0)
      xfer_en = 4'h0;
   endtask

   task automatic t_wrap();
      bus(1, SEL_COUNT, 16'h1234);
      clr_a = 0;
      wr_tick(SEL_COUNT, 16'h1234);
      bus(0, SEL_COUNT, 16'h0);
      `CHK(rd, 16'h1234)
      bus(1, SEL_COUNT, CNT_MAX);
      tick = 1;
      @(negedge ref_clk);
      tick = 0;
      `CHK(flags[FLG_OVF], 1'b1)
      @(negedge ref_clk);
      `CHK(ovf_irq, 1'b1)
      down = 1;
      bus(1, SEL_COUNT, CNT_ZERO);
      tick = 1;
      @(negedge ref_clk);
      tick = 0;
      `CHK(flags[FLG_UNF], 1'b1)
      @(negedge ref_clk);
      `CHK(unf_irq, 1'b1)
      bus(0, SEL_COUNT, 16'h0);
      `CHK(rd, CNT_MAX)
      down  = 0;
      clr_a = 1;
      bus(1, SEL_COUNT, 16'h0003);
      wr_tick(SEL_COUNT, 16'h1234);
      bus(0, SEL_COUNT, 16'h0);
      `CHK(rd, CNT_ZERO)
      clr_a = 0;
      // Buffer write to C while A matches: channel 0 new data, channel 4 old
      bus(1, SEL_COUNT, 16'h0003);
      buf_en = 1;
      wr_tick(SEL_GCC_A + 3'(REG_C), 16'h0777);
      bus(0, SEL_GCC_A, 16'h0);
      `CHK(alt_rdata[0], 16'h0777)
      `CHK(alt_rdata[1], GCC_RST)
      buf_en = 0;
   endtask

   task automatic t_capture();
      // Clear every flag, then count down onto zero
      down = 1;
      bus(1, SEL_COUNT, CNT_ONE);
      bus(0, SEL_FLAGS, 16'h0);
      bus(1, SEL_FLAGS, 16'h0);
      `CHK(flags, 6'h00)
      tick = 1;
      @(negedge ref_clk);
      tick = 0;
      down = 0;
      `CHK(alt_flags[1][FLG_OVF], 1'b1)
      `CHK(flags[FLG_OVF], 1'b0)
      cap_mode = 4'h2;
      edge_sel = {4'h0, EDGE_RISE, 2'h0};
      bus(1, SEL_COUNT, 16'h0055);
      `CHK(pin_oe, 4'hd)
      pin_in = 4'h2;
      wait_bit(1, 1'b1);
      `CHK(flags[1], 1'b1)
      `CHK(mc_irq[1], 1'b0)
      @(negedge ref_clk);
      `CHK(mc_irq[1], 1'b1)
      bus(0, 3'h2, 16'h0);
      `CHK(rd, 16'h0055)
      // Capture on register A in the first state of its read
      cap_mode = 4'h3;
      edge_sel = {4'h0, EDGE_RISE, EDGE_RISE};
      fork
         bus(0, SEL_GCC_A, 16'h0);
         begin
            @(negedge ref_clk);
            pin_in = 4'h3;
         end
      join
      `CHK(rd, 16'h0055)
      pin_in = 4'h0;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      resetn = 1;
      @(negedge ref_clk);
      `CHK(flags, 6'h00)
      t_match();
      t_wrap();
      t_capture();
      wrap_up();
   end
endmodule
